//--- include/tct_pkg.sv
// Constants of the thermal clock throttle: register map, field layout, timing.
// Assumes a 250 MHz core clock; all counts below are in core clock cycles.
package tct_pkg;
    // Register byte addresses on the AXI4-Lite bus.
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    // Control register fields.
    localparam int CTRL_AUTO_EN_BIT = 0;
    localparam int CTRL_DUTY_LSB = 1;
    localparam int CTRL_DUTY_MSB = 3;
    localparam int CTRL_ONDEMAND_BIT = 4;
    localparam int CTRL_EVT_ENTER_BIT = 5;
    localparam int CTRL_EVT_EXIT_BIT = 6;
    localparam int CTRL_WIDTH = 7;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    // Status register fields.
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_AUTO_BIT = 1;
    localparam int STAT_TRIP_BIT = 2;
    localparam int STAT_CLKEN_BIT = 3;
    localparam int STAT_ONDEMAND_BIT = 4;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Timing.
    localparam int CLK_MHZ = 250;
    localparam int MAX_PHASE_TIME_US = 3000;
    localparam int MAX_PHASE_CYC = MAX_PHASE_TIME_US * CLK_MHZ;
    localparam int HYST_TIME_US = 1000;
    localparam int HYST_CYC = HYST_TIME_US * CLK_MHZ;
    // Modulation period of 8 slots of 128 cycles each.
    localparam int MOD_CNT_W = 10;
    localparam int MOD_PERIOD_CYC = 1 << MOD_CNT_W;
    localparam logic [2:0] AUTO_ON_EIGHTHS = 3'h3;
    localparam logic [2:0] RESERVED_DUTY_EIGHTHS = 3'h4;
    // Automatic-mode sequencing.
    typedef enum logic [1:0] {
        AUTO_IDLE = 2'b00,
        AUTO_HOT = 2'b01,
        AUTO_HYST = 2'b10
    } tct_auto_t;
endpackage

//--- core/tct_thermal_clock_throttle.sv
// Thermal clock throttle: gates the core clock enable at a duty cycle while throttling.
// Assumes the sensor trip levels arrive asynchronously and the clock gate sits outside.
//
// How it works
// - Core clock enable is switched off and on repeatedly while throttling is active.
// - Throttling activates from the automatic temperature path or the on-demand bit.
// - Automatic throttling starts only when the near-limit sensor trip is reported.
// - Automatic duty keeps the clock running three eighths of each period.
// - No on or off stretch exceeds 3.0 ms while throttling.
// - The modulation period is a fixed count of core clock cycles.
// - Automatic throttling ends after the trip clears and a hysteresis timer expires.
// - Automatic duty is a fixed constant that software cannot alter.
// - Writing one to control bit 4 activates throttling at once, regardless of temperature.
// - Control bits 3:1 pick on-demand on time in eighths of the period.
// - Automatic duty overrides on-demand duty while the hot condition holds.
// - The active-low hot indicator stays asserted while throttling is active.
// - Snoop and interrupt latch clocking stays running during throttling.
// - The trip temperature is fixed outside and not readable or writable here.
// - Optional event pulses mark start and end of throttling.
// - The catastrophic trip stops the core whatever the mode settings.
// - The thermal trip output latches until reset with the die cooled.
// - The thermal trip output acts without software and issues no bus cycle.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module tct_thermal_clock_throttle #(
    parameter int HYST_CYCLES = tct_pkg::HYST_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Sensor trip levels, asynchronous
    input wire logic nearLimitHot,
    input wire logic catastrophicHot,
    // Clock control and pins
    output logic coreClkEn,
    output logic snoopClkEn,
    output logic hot_indicator_n,
    output logic thermal_trip_n,
    // Throttle event pulses
    output logic throttleStartEvt,
    output logic throttleStopEvt,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam int HYST_W = $clog2(HYST_CYCLES + 1);
    localparam int PHASE_W = $clog2(tct_pkg::MAX_PHASE_CYC + 1);

    // Three-stage synchronisers; the filtered level moves only when stages two and three agree.
    logic [2:0] hotSync_reg;
    logic [2:0] catSync_reg;
    logic hotLevel_reg;
    logic catLevel_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            hotSync_reg <= 3'h0;
            hotLevel_reg <= 1'b0;
        end else begin
            hotSync_reg <= {hotSync_reg[1:0], nearLimitHot};
            if (hotSync_reg[1] == hotSync_reg[2]) begin
                hotLevel_reg <= hotSync_reg[2];
            end
        end
    end

    // The catastrophic path keeps sampling through reset, so a reset taken while the die
    // is still too hot does not release the trip output even for a few cycles.
    always_ff @(posedge clk) begin
        catSync_reg <= {catSync_reg[1:0], catastrophicHot};
        if (catSync_reg[1] == catSync_reg[2]) begin
            catLevel_reg <= catSync_reg[2];
        end
    end

    // Control register and bus state.
    logic [tct_pkg::CTRL_WIDTH-1:0] ctrl_reg;
    logic awHeld_reg;
    logic wHeld_reg;
    logic [7:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;

    wire logic autoEnable = ctrl_reg[tct_pkg::CTRL_AUTO_EN_BIT];
    wire logic onDemand = ctrl_reg[tct_pkg::CTRL_ONDEMAND_BIT];
    wire logic [2:0] dutyField = ctrl_reg[tct_pkg::CTRL_DUTY_MSB:tct_pkg::CTRL_DUTY_LSB];

    // Automatic mode sequencer.
    tct_pkg::tct_auto_t autoState_reg;
    tct_pkg::tct_auto_t autoState_next;
    logic [HYST_W-1:0] hystCnt_reg;
    logic [HYST_W-1:0] hystCnt_next;

    wire logic hystDone = (hystCnt_reg == '0);

    always_comb begin
        autoState_next = autoState_reg;
        hystCnt_next = hystCnt_reg;
        unique case (autoState_reg)
            tct_pkg::AUTO_IDLE: begin
                if (autoEnable && hotLevel_reg) begin
                    autoState_next = tct_pkg::AUTO_HOT;
                end
            end
            tct_pkg::AUTO_HOT: begin
                if (!autoEnable) begin
                    autoState_next = tct_pkg::AUTO_IDLE;
                end else if (!hotLevel_reg) begin
                    autoState_next = tct_pkg::AUTO_HYST;
                    hystCnt_next = HYST_W'(HYST_CYCLES - 1);
                end
            end
            tct_pkg::AUTO_HYST: begin
                if (!autoEnable) begin
                    autoState_next = tct_pkg::AUTO_IDLE;
                end else if (hotLevel_reg) begin
                    autoState_next = tct_pkg::AUTO_HOT;
                end else if (hystDone) begin
                    autoState_next = tct_pkg::AUTO_IDLE;
                end else begin
                    hystCnt_next = hystCnt_reg - 1'b1;
                end
            end
            default: begin
                autoState_next = tct_pkg::AUTO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            autoState_reg <= tct_pkg::AUTO_IDLE;
            hystCnt_reg <= '0;
        end else begin
            autoState_reg <= autoState_next;
            hystCnt_reg <= hystCnt_next;
        end
    end

    // Activation and duty selection.
    wire logic autoActive = (autoState_reg != tct_pkg::AUTO_IDLE);
    wire logic autoOverride = (autoState_reg == tct_pkg::AUTO_HOT);
    wire logic throttleActive = autoActive || onDemand;
    // A reserved zero field falls back to half duty rather than stopping the core outright.
    wire logic [2:0] demandEighths = (dutyField == 3'h0) ?
        tct_pkg::RESERVED_DUTY_EIGHTHS : dutyField;
    // Hysteresis keeps the automatic duty too, so leaving hot does not speed the core early.
    wire logic [2:0] onEighths = (autoActive || autoOverride) ?
        tct_pkg::AUTO_ON_EIGHTHS : demandEighths;

    // The period is 1024 cycles, far below the 3.0 ms bound for any stretch.
    logic [tct_pkg::MOD_CNT_W-1:0] modCnt_reg;
    wire logic [2:0] modSlot = modCnt_reg[tct_pkg::MOD_CNT_W-1:tct_pkg::MOD_CNT_W-3];
    wire logic modOn = (modSlot < onEighths);

    always_ff @(posedge clk) begin
        if (!rstn || !throttleActive) begin
            modCnt_reg <= '0;
        end else begin
            modCnt_reg <= modCnt_reg + 1'b1;
        end
    end

    // Catastrophic trip latches until a reset taken after the die has cooled.
    logic trip_reg;
    logic active_reg;
    logic clkEn_reg;
    logic startEvt_reg;
    logic stopEvt_reg;
    logic [PHASE_W-1:0] phaseCnt_reg;

    wire logic tripAny = trip_reg || catLevel_reg;
    wire logic clkEnWant = !tripAny && (!throttleActive || modOn);
    // Each on or off stretch is counted as a backstop: one reaching the limit is cut by a
    // single flip of the enable, so the bound holds even if the period is rebuilt longer.
    wire logic phaseLimit = (phaseCnt_reg == PHASE_W'(tct_pkg::MAX_PHASE_CYC - 1));
    wire logic stretchCut = throttleActive && phaseLimit;
    wire logic clkEnNext = tripAny ? 1'b0 : (stretchCut ? !clkEn_reg : clkEnWant);

    always_ff @(posedge clk) begin
        if (!rstn || !throttleActive || tripAny || (clkEnNext != clkEn_reg)) begin
            phaseCnt_reg <= '0;
        end else begin
            phaseCnt_reg <= phaseCnt_reg + 1'b1;
        end
    end

    // Reset keeps the trip and the stopped core while the die is still too hot.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            trip_reg <= catLevel_reg;
            active_reg <= 1'b0;
            clkEn_reg <= !catLevel_reg;
        end else begin
            trip_reg <= tripAny;
            active_reg <= throttleActive;
            clkEn_reg <= clkEnNext;
        end
    end

    // Events follow the registered active level, so they line up with the indicator edges.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            startEvt_reg <= 1'b0;
            stopEvt_reg <= 1'b0;
        end else begin
            startEvt_reg <= throttleActive && !active_reg &&
                ctrl_reg[tct_pkg::CTRL_EVT_ENTER_BIT];
            stopEvt_reg <= !throttleActive && active_reg &&
                ctrl_reg[tct_pkg::CTRL_EVT_EXIT_BIT];
        end
    end

    assign coreClkEn = clkEn_reg;
    assign snoopClkEn = !trip_reg;
    assign hot_indicator_n = !active_reg;
    assign thermal_trip_n = !trip_reg;
    assign throttleStartEvt = startEvt_reg;
    assign throttleStopEvt = stopEvt_reg;

    // AXI4-Lite write path: address and data are taken in either order, then answered.
    logic bValid_reg;
    logic [1:0] bResp_reg;

    assign s_axi_awready = !awHeld_reg && !bValid_reg;
    assign s_axi_wready = !wHeld_reg && !bValid_reg;
    wire logic awTake = s_axi_awvalid && s_axi_awready;
    wire logic wTake = s_axi_wvalid && s_axi_wready;
    wire logic awHave = awHeld_reg || awTake;
    wire logic wHave = wHeld_reg || wTake;
    wire logic [7:0] wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
    wire logic [31:0] wrData = wHeld_reg ? wData_reg : s_axi_wdata;
    wire logic [3:0] wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
    wire logic wrFire = awHave && wHave && !bValid_reg;
    wire logic wrCtrl = (wrAddr == tct_pkg::CTRL_OFFSET);
    wire logic wrStat = (wrAddr == tct_pkg::STATUS_OFFSET);

    wire logic ctrlLoad = wrFire && wrCtrl && wrStrb[0];

    // Address and data are parked here until their partner arrives.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            awAddr_reg <= 8'h00;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
        end else begin
            if (awTake) begin
                awAddr_reg <= s_axi_awaddr;
            end
            if (wTake) begin
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            bValid_reg <= 1'b0;
            bResp_reg <= tct_pkg::RESP_OKAY;
        end else if (wrFire) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            bValid_reg <= 1'b1;
            bResp_reg <= (wrCtrl || wrStat) ? tct_pkg::RESP_OKAY : tct_pkg::RESP_DECERR;
        end else begin
            awHeld_reg <= awHave;
            wHeld_reg <= wHave;
            if (bValid_reg && s_axi_bready) begin
                bValid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_reg <= tct_pkg::CTRL_RESET;
        end else if (ctrlLoad) begin
            ctrl_reg <= wrData[tct_pkg::CTRL_WIDTH-1:0];
        end
    end

    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp = bResp_reg;

    // AXI4-Lite read path; the trip level itself is never exposed.
    logic rValid_reg;
    logic [31:0] rData_reg;
    logic [1:0] rResp_reg;

    assign s_axi_arready = !rValid_reg;
    wire logic arTake = s_axi_arvalid && s_axi_arready;
    wire logic rdCtrl = (s_axi_araddr == tct_pkg::CTRL_OFFSET);
    wire logic rdStat = (s_axi_araddr == tct_pkg::STATUS_OFFSET);
    wire logic [31:0] ctrlWord = {25'h0000000, ctrl_reg};
    wire logic [31:0] statWord = {27'h0000000, onDemand, clkEn_reg, trip_reg,
        autoActive, active_reg};
    wire logic [31:0] rdWord = rdCtrl ? ctrlWord : (rdStat ? statWord : 32'h0000_0000);
    wire logic [1:0] rdResp = (rdCtrl || rdStat) ? tct_pkg::RESP_OKAY : tct_pkg::RESP_DECERR;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rValid_reg <= 1'b0;
            rData_reg <= 32'h0000_0000;
            rResp_reg <= tct_pkg::RESP_OKAY;
        end else if (arTake) begin
            rValid_reg <= 1'b1;
            rData_reg <= rdWord;
            rResp_reg <= rdResp;
        end else if (rValid_reg && s_axi_rready) begin
            rValid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rdata = rData_reg;
    assign s_axi_rresp = rResp_reg;

endmodule // tct_thermal_clock_throttle
`default_nettype wire

//--- verif/tct_throttle_properties.sv
// Assertion checker for the thermal clock throttle, seeing only its top-level ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module tct_throttle_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pins and events
    input wire logic coreClkEn,
    input wire logic snoopClkEn,
    input wire logic hot_indicator_n,
    input wire logic thermal_trip_n,
    input wire logic throttleStartEvt,
    input wire logic throttleStopEvt,
    // Bus answers
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_arready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Length of the current on or off stretch; cleared while not throttling.
    logic lastEn_reg;
    int len_reg;
    wire logic lenClear = !rstn || hot_indicator_n || !thermal_trip_n || coreClkEn != lastEn_reg;
    wire logic [31:0] len_next = lenClear ? 32'h0000_0000 : len_reg + 1;
    always_ff @(posedge clk) begin
        lastEn_reg <= coreClkEn;
        len_reg <= len_next;
    end
    property p_stretch; len_reg < tct_pkg::MOD_PERIOD_CYC; endproperty
    a_stretch: assert property (p_stretch) else $error("clock stretch too long");
    property p_tripHold; !thermal_trip_n |=> !thermal_trip_n; endproperty
    a_tripHold: assert property (p_tripHold) else $error("trip released");
    property p_tripStop; !thermal_trip_n [*2] |-> !coreClkEn && !snoopClkEn; endproperty
    a_tripStop: assert property (p_tripStop) else $error("clock runs after trip");
    property p_snoop; thermal_trip_n |-> snoopClkEn; endproperty
    a_snoop: assert property (p_snoop) else $error("snoop clock stopped");
    property p_idle; (hot_indicator_n && thermal_trip_n) [*4] |-> coreClkEn; endproperty
    a_idle: assert property (p_idle) else $error("clock gated while idle");
    property p_start; throttleStartEvt |-> !hot_indicator_n; endproperty
    a_start: assert property (p_start) else $error("start event while idle");
    property p_stop; throttleStopEvt |-> hot_indicator_n; endproperty
    a_stop: assert property (p_stop) else $error("stop event while active");
    property p_bOnce; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bOnce: assert property (p_bOnce) else $error("second write response");
    property p_rBlock; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rBlock: assert property (p_rBlock) else $error("read taken while answering");
    c_start: cover property (throttleStartEvt);
    c_trip: cover property ($fell(thermal_trip_n));
    c_gate: cover property ($fell(coreClkEn) && !hot_indicator_n);
endmodule // tct_throttle_checker
bind tct_thermal_clock_throttle tct_throttle_checker i_tct_throttle_checker (.clk, .rstn,
    .coreClkEn, .snoopClkEn, .hot_indicator_n, .thermal_trip_n, .throttleStartEvt,
    .throttleStopEvt, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_arready);
`default_nettype wire

//--- verif/tct_sensor_model.sv
// Die sensor model that feeds the throttle its two trip levels.
// Assumes the bench asks for heat or a cooling failure by level.
`timescale 1ns/10ps
`default_nettype none
module tct_sensor_model (
    // Clock
    input wire logic clk,
    // Bench requests
    input wire logic heatReq,
    input wire logic tripReq,
    // Trip levels
    output logic nearLimitHot = 1'b0,
    output logic catastrophicHot = 1'b0
);
    // Levels move off the edge, as an unsynchronised sensor would.
    always @(posedge clk) begin
        nearLimitHot <= #1 heatReq;
        catastrophicHot <= #1 tripReq;
    end
endmodule // tct_sensor_model
`default_nettype wire

//--- verif/test_thermal_clock_throttle.sv
// Self-checking bench for the thermal clock throttle.
// Assumes a 4 ns clock; the hysteresis count is shortened to 16 cycles.
`timescale 1ns/10ps
`default_nettype none
module test_thermal_clock_throttle;
    logic clk = 1'b0, rstn = 1'b0, heatReq = 1'b0, tripReq = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic lane0 = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, nearLimitHot, catastrophicHot;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic coreClkEn, snoopClkEn, hot_indicator_n, thermal_trip_n;
    logic throttleStartEvt, throttleStopEvt;
    int bad_count = 0, compares = 0, cyc = 0, seed = 90, starts = 0, stops = 0;
    logic [33:0] rdQ[$];
    logic [1:0] wrQ[$];
    always #2 clk = ~clk;
    tct_thermal_clock_throttle #(.HYST_CYCLES(16)) i_tct_thermal_clock_throttle (.clk, .rstn,
        .nearLimitHot, .catastrophicHot, .coreClkEn, .snoopClkEn, .hot_indicator_n,
        .thermal_trip_n, .throttleStartEvt, .throttleStopEvt, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    tct_sensor_model i_tct_sensor_model (.clk, .heatReq, .tripReq, .nearLimitHot,
        .catastrophicHot);
    task automatic chk_bus(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: bus %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: level %0d not %0d", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [6:0] v, input logic [1:0] r);
        logic [31:0] rnd;
        logic aR, wR, bR;
        rnd = $random(seed);
        wrQ.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {rnd[31:7], v};
        s_axi_wstrb <= {rnd[3:1], lane0};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge clk);
            aR = s_axi_awvalid && s_axi_awready;
            wR = s_axi_wvalid && s_axi_wready;
            bR = s_axi_bvalid;
            @(posedge clk);
            if (aR) s_axi_awvalid <= 1'b0;
            if (wR) s_axi_wvalid <= 1'b0;
        end while (!bR);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        logic aR, rR;
        rdQ.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge clk);
            aR = s_axi_arvalid && s_axi_arready;
            rR = s_axi_rvalid;
            @(posedge clk);
            if (aR) s_axi_arvalid <= 1'b0;
        end while (!rR);
    endtask
    // Counts running cycles over one whole modulation period once it has settled.
    task automatic duty(output int n);
        n = 0;
        repeat (1100) @(posedge clk);
        repeat (tct_pkg::MOD_PERIOD_CYC) begin
            @(negedge clk);
            if (coreClkEn === 1'b1) n++;
        end
        @(posedge clk);
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(negedge clk) begin
        if (s_axi_rvalid === 1'b1) chk_bus({s_axi_rresp, s_axi_rdata}, rdQ.pop_front());
        if (s_axi_bvalid === 1'b1) chk_bus({s_axi_bresp, 32'h0}, {wrQ.pop_front(), 32'h0});
        if (throttleStartEvt === 1'b1) starts++;
        if (throttleStopEvt === 1'b1) stops++;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            print_verdict;
        end
    end
    initial begin
        int n;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(tct_pkg::STATUS_OFFSET, {tct_pkg::RESP_OKAY, 32'h8});
        rd(8'h08, {tct_pkg::RESP_DECERR, 32'h0});
        wr(8'h08, 7'h10, tct_pkg::RESP_DECERR);
        wr(tct_pkg::STATUS_OFFSET, 7'h10, tct_pkg::RESP_OKAY);
        lane0 = 1'b0;
        wr(tct_pkg::CTRL_OFFSET, 7'h10, tct_pkg::RESP_OKAY);
        lane0 = 1'b1;
        rd(tct_pkg::CTRL_OFFSET, {tct_pkg::RESP_OKAY, 32'h0});
        $display("test registers done");
        for (int d = 0; d < 8; d++) begin
            wr(tct_pkg::CTRL_OFFSET, {3'h7, d[2:0], 1'b0}, tct_pkg::RESP_OKAY);
            rd(tct_pkg::CTRL_OFFSET, {tct_pkg::RESP_OKAY, 25'h0, 3'h7, d[2:0], 1'b0});
            chk_pin(hot_indicator_n, 1'b0);
            duty(n);
            chk_pin(n, (d == 0 ? 4 : d) * 128);
        end
        wr(tct_pkg::CTRL_OFFSET, 7'h60, tct_pkg::RESP_OKAY);
        repeat (8) @(posedge clk);
        chk_pin({starts[15:0], stops[15:0]}, 32'h00010001);
        $display("test on-demand done");
        heatReq <= 1'b1;
        wr(tct_pkg::CTRL_OFFSET, 7'h1f, tct_pkg::RESP_OKAY);
        duty(n);
        chk_pin(n, 384);
        wr(tct_pkg::CTRL_OFFSET, 7'h01, tct_pkg::RESP_OKAY);
        duty(n);
        chk_pin(n, 384);
        heatReq <= 1'b0;
        repeat (10) @(posedge clk);
        chk_pin(hot_indicator_n, 1'b0);
        repeat (60) @(posedge clk);
        chk_pin({hot_indicator_n, starts[3:0], stops[3:0]}, 9'h111);
        wr(tct_pkg::CTRL_OFFSET, 7'h00, tct_pkg::RESP_OKAY);
        heatReq <= 1'b1;
        repeat (50) @(posedge clk);
        chk_pin(hot_indicator_n, 1'b1);
        heatReq <= 1'b0;
        $display("test automatic done");
        tripReq <= 1'b1;
        repeat (10) @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk_pin({thermal_trip_n, coreClkEn, snoopClkEn}, 3'h0);
        tripReq <= 1'b0;
        repeat (10) @(posedge clk);
        chk_pin({thermal_trip_n, coreClkEn, snoopClkEn}, 3'h0);
        rd(tct_pkg::STATUS_OFFSET, {tct_pkg::RESP_OKAY, 32'h4});
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk_pin(thermal_trip_n, 1'b1);
        $display("test trip done");
        print_verdict;
    end
endmodule // test_thermal_clock_throttle
`default_nettype wire
